// ==== verilog/fulc_regs.vh ====
// Register indices, field positions and reset values for the UART
`ifndef FULC_REGS_VH
`define FULC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FULC_IDX_DATA      10'h000
`define FULC_IDX_BAUD      10'h001
`define FULC_IDX_IRQ_STAT  10'h002
`define FULC_IDX_IRQ_CLR   10'h003
`define FULC_IDX_IRQ_EN    10'h004
`define FULC_IDX_FIFO      10'h0a5
`define FULC_IDX_LINE      10'h0c2

// ----------------------------------------------------------------------
// Line format control fields
// ----------------------------------------------------------------------
`define FULC_LINE_EN       7
`define FULC_LINE_STOP2    6
`define FULC_LINE_LEN_HI   5
`define FULC_LINE_LEN_LO   4
`define FULC_LINE_BRK      3
`define FULC_LINE_ODD      2
`define FULC_LINE_PAR      1
`define FULC_LINE_FORCE    0

// ----------------------------------------------------------------------
// FIFO level and threshold fields
// ----------------------------------------------------------------------
`define FULC_FIFO_RX_HI    7
`define FULC_FIFO_RX_LO    4
`define FULC_FIFO_TX_HI    3
`define FULC_FIFO_TX_LO    0
`define FULC_RX_THR_CLEAR  4'hf
`define FULC_TX_THR_CLEAR  4'h0
`define FULC_FIFO_DEPTH    4'hf

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define FULC_IRQ_RX_LEVEL  0
`define FULC_IRQ_TX_LEVEL  1
`define FULC_IRQ_PAR_ERR   2
`define FULC_IRQ_RX_OVF    3
`define FULC_IRQ_TX_OVF    4
`define FULC_IRQ_BITS      5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FULC_LINE_RST      8'h00
`define FULC_BAUD_RST      16'h0000
`define FULC_THR_RST       4'h0
`define FULC_IRQ_EN_RST    5'h00

`endif

// ==== verilog/fulc_mem.v ====
// Small FIFO storage with registered read data
`timescale 1ns/100ps
module fulc_mem (
    input  wire       clk_i,
    input  wire       we_i,
    input  wire [3:0] waddr_i,
    input  wire [8:0] wdata_i,
    input  wire [3:0] raddr_i,
    output reg  [8:0] rdata_o
);
    reg [8:0] mem [0:15];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // fulc_mem

// ==== verilog/fulc_top.v ====
// Serial controller: line format, FIFO levels, Wishbone registers
`timescale 1ns/100ps
// Overview of operation
// - Separate transmit and receive FIFOs, each holding 15 bytes.
// - Each FIFO has its own programmable interrupt trigger level.
// - Bit timing comes from a private 16-bit baud divisor.
// - Enable set: send queued bytes and store received; clear: neither.
// - Stop select set gives two stop bits, clear gives one.
// - Length field 00..11 gives five to eight data bits.
// - Break bit holds the transmit line low until software clears it.
// - Odd/even bit picks parity sense for sending and checking.
// - Parity enable adds parity bit and checking; clear removes both.
// - Parity bit position reads fault flag of receive FIFO head byte.
// - Forced parity sends a constant one as parity bit.
// - Upper FIFO nibble write sets receive threshold, code equals level.
// - All-ones receive threshold resets receiver and empties receive FIFO.
// - Lower FIFO nibble reads transmit FIFO byte count.
// - Zero divisor with enable clear empties FIFOs and clears overflows.
`include "fulc_regs.vh"
module fulc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:2] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        rxd_i,
    output reg         txd_o,
    output reg         irq_o
);
    localparam S_IDLE  = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_PAR   = 3'h3;
    localparam S_STOP  = 3'h4;

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    function [3:0] char_bits;
        input [1:0] len;
        begin
            char_bits = 4'h5 + {2'h0, len};
        end
    endfunction

    function par_value;
        input [7:0] d;
        input       odd;
        input       force1;
        begin
            par_value = force1 ? 1'b1 : (odd ? ~^d : ^d);
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0]  line;
    reg  [15:0] baud_divisor;
    reg  [3:0]  rx_irq_threshold;
    reg  [3:0]  tx_irq_threshold;
    reg  [4:0]  irq_stat;
    reg  [4:0]  irq_en;

    wire serial_enable     = line[`FULC_LINE_EN];
    wire two_stop_select   = line[`FULC_LINE_STOP2];
    wire [1:0] char_length_field = line[`FULC_LINE_LEN_HI:`FULC_LINE_LEN_LO];
    wire parity_odd_even   = line[`FULC_LINE_ODD];
    wire parity_check_on   = line[`FULC_LINE_PAR];
    wire parity_forced_one = line[`FULC_LINE_FORCE];
    wire [3:0] nbits       = char_bits(char_length_field);

    wire acc     = cyc_i & stb_i & ack_o;
    wire wr      = acc & we_i & sel_i[0];
    wire hit_dat = adr_i == `FULC_IDX_DATA;
    wire hit_fif = adr_i == `FULC_IDX_FIFO;

    // Divisor zero while disabled acts as a flush of both directions
    wire flush   = (baud_divisor == 16'h0000) & ~serial_enable;
    wire rx_clr  = flush | (wr & hit_fif &
                   dat_i[7:4] == `FULC_RX_THR_CLEAR);
    wire tx_clr  = flush | (wr & hit_fif &
                   dat_i[3:0] == `FULC_TX_THR_CLEAR);

    // ------------------------------------------------------------------
    // FIFO pointers
    // ------------------------------------------------------------------
    reg  [3:0] tx_wp, tx_rp, tx_fill_count;
    reg  [3:0] rx_wp, rx_rp, rx_fill_count;
    wire [8:0] tx_q, rx_q;
    reg        tx_pop, rx_push, tx_arm;
    reg  [8:0] rx_word;

    wire tx_full  = tx_fill_count == `FULC_FIFO_DEPTH;
    wire rx_full  = rx_fill_count == `FULC_FIFO_DEPTH;
    wire tx_push  = wr & hit_dat & ~tx_full;
    wire rx_pop   = acc & ~we_i & hit_dat & (rx_fill_count != 4'h0);
    wire rx_wr    = rx_push & ~rx_full;

    fulc_mem u_tx_mem (
        .clk_i   (clk_i),
        .we_i    (tx_push),
        .waddr_i (tx_wp),
        .wdata_i ({1'b0, dat_i[7:0]}),
        .raddr_i (tx_rp),
        .rdata_o (tx_q)
    );

    fulc_mem u_rx_mem (
        .clk_i   (clk_i),
        .we_i    (rx_wr),
        .waddr_i (rx_wp),
        .wdata_i (rx_word),
        .raddr_i (rx_rp),
        .rdata_o (rx_q)
    );

    always @(posedge clk_i) begin
        if (rst_i || tx_clr) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_fill_count <= 4'h0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 4'h1;
            end
            if (tx_pop) begin
                tx_rp <= tx_rp + 4'h1;
            end
            tx_fill_count <= tx_fill_count + {3'h0, tx_push}
                             - {3'h0, tx_pop};
        end
        if (rst_i || rx_clr) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_fill_count <= 4'h0;
        end else begin
            if (rx_wr) begin
                rx_wp <= rx_wp + 4'h1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 4'h1;
            end
            rx_fill_count <= rx_fill_count + {3'h0, rx_wr}
                             - {3'h0, rx_pop};
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    reg [2:0]  tx_st;
    reg [15:0] tx_cnt;
    reg [7:0]  tx_sh;
    reg [3:0]  tx_bn;
    reg        tx_par, tx_line, tx_stop2;

    always @(posedge clk_i) begin
        tx_pop <= 1'b0;
        if (rst_i || tx_clr) begin
            tx_st   <= S_IDLE;
            tx_cnt  <= 16'h0000;
            tx_sh   <= 8'h00;
            tx_bn   <= 4'h0;
            tx_par  <= 1'b0;
            tx_line <= 1'b1;
            tx_stop2 <= 1'b0;
            tx_arm  <= 1'b0;
        end else begin
            // Memory read lags a write by one cycle, so wait one more
            tx_arm <= tx_fill_count != 4'h0;
            case (tx_st)
            S_IDLE: begin
                tx_line <= 1'b1;
                if (serial_enable && tx_arm && tx_fill_count != 4'h0 &&
                    !tx_pop) begin
                    tx_sh   <= tx_q[7:0];
                    tx_par  <= par_value(tx_q[7:0] &
                               (8'hff >> (4'h8 - nbits)),
                               parity_odd_even, parity_forced_one);
                    tx_pop  <= 1'b1;
                    tx_line <= 1'b0;
                    tx_cnt  <= baud_divisor;
                    tx_st   <= S_START;
                end
            end
            default: begin
                if (tx_cnt != 16'h0000) begin
                    tx_cnt <= tx_cnt - 16'h0001;
                end else begin
                    tx_cnt <= baud_divisor;
                    case (tx_st)
                    S_START: begin
                        tx_line <= tx_sh[0];
                        tx_sh   <= tx_sh >> 1;
                        tx_bn   <= nbits - 4'h1;
                        tx_st   <= S_DATA;
                    end
                    S_DATA: begin
                        if (tx_bn != 4'h0) begin
                            tx_line <= tx_sh[0];
                            tx_sh   <= tx_sh >> 1;
                            tx_bn   <= tx_bn - 4'h1;
                        end else if (parity_check_on) begin
                            tx_line <= tx_par;
                            tx_st   <= S_PAR;
                        end else begin
                            tx_line  <= 1'b1;
                            tx_stop2 <= two_stop_select;
                            tx_st    <= S_STOP;
                        end
                    end
                    S_PAR: begin
                        tx_line  <= 1'b1;
                        tx_stop2 <= two_stop_select;
                        tx_st    <= S_STOP;
                    end
                    default: begin
                        tx_stop2 <= 1'b0;
                        if (!tx_stop2) begin
                            tx_st <= S_IDLE;
                        end
                    end
                    endcase
                end
            end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    reg        rx_s1, rx_s2, rx_prev;
    reg [2:0]  rx_st;
    reg [15:0] rx_cnt;
    reg [7:0]  rx_sh;
    reg [3:0]  rx_bn;
    reg        rx_parity_fault_flag;
    wire [7:0] rx_byte = rx_sh >> (4'h8 - nbits);

    always @(posedge clk_i) begin
        rx_s1   <= rxd_i;
        rx_s2   <= rx_s1;
        rx_prev <= rx_s2;
        rx_push <= 1'b0;
        if (rst_i || rx_clr) begin
            rx_st   <= S_IDLE;
            rx_cnt  <= 16'h0000;
            rx_sh   <= 8'h00;
            rx_bn   <= 4'h0;
            rx_parity_fault_flag <= 1'b0;
            rx_word <= 9'h000;
        end else begin
            case (rx_st)
            S_IDLE: begin
                rx_parity_fault_flag <= 1'b0;
                if (serial_enable && rx_prev && !rx_s2) begin
                    rx_cnt <= {1'b0, baud_divisor[15:1]};
                    rx_st  <= S_START;
                end
            end
            default: begin
                if (rx_cnt != 16'h0000) begin
                    rx_cnt <= rx_cnt - 16'h0001;
                end else begin
                    rx_cnt <= baud_divisor;
                    case (rx_st)
                    S_START: begin
                        rx_bn <= nbits;
                        rx_st <= rx_s2 ? S_IDLE : S_DATA;
                    end
                    S_DATA: begin
                        rx_sh <= {rx_s2, rx_sh[7:1]};
                        rx_bn <= rx_bn - 4'h1;
                        if (rx_bn == 4'h1) begin
                            rx_st <= parity_check_on ? S_PAR : S_STOP;
                        end
                    end
                    S_PAR: begin
                        rx_parity_fault_flag <= rx_s2 != par_value(rx_byte,
                                   parity_odd_even,
                                   parity_forced_one);
                        rx_st <= S_STOP;
                    end
                    default: begin
                        // A bad stop bit drops the character
                        if (rx_s2) begin
                            rx_word <= {rx_parity_fault_flag, rx_byte};
                            rx_push <= 1'b1;
                        end
                        rx_st <= S_IDLE;
                    end
                    endcase
                end
            end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    wire [4:0] irq_evt;
    assign irq_evt[`FULC_IRQ_RX_LEVEL] =
        rx_fill_count >= rx_irq_threshold;
    assign irq_evt[`FULC_IRQ_TX_LEVEL] =
        tx_fill_count < tx_irq_threshold;
    assign irq_evt[`FULC_IRQ_PAR_ERR] = rx_wr & rx_word[8];
    assign irq_evt[`FULC_IRQ_RX_OVF]  = rx_push & rx_full;
    assign irq_evt[`FULC_IRQ_TX_OVF]  = wr & hit_dat & tx_full;

    wire [4:0] irq_clr = (wr && adr_i == `FULC_IDX_IRQ_CLR) ?
                         dat_i[4:0] : 5'h00;
    wire [4:0] ovf_clr = flush ? 5'h18 : 5'h00;

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 5'h00;
            irq_o    <= 1'b0;
        end else begin
            // A new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~(irq_clr | ovf_clr)) | irq_evt;
            irq_o    <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    wire head_parity_fault_flag = (rx_fill_count != 4'h0) & rx_q[8];

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o            <= 1'b0;
            dat_o            <= 32'h00000000;
            line             <= `FULC_LINE_RST;
            baud_divisor     <= `FULC_BAUD_RST;
            rx_irq_threshold <= `FULC_THR_RST;
            tx_irq_threshold <= `FULC_THR_RST;
            irq_en           <= `FULC_IRQ_EN_RST;
            txd_o            <= 1'b1;
        end else begin
            txd_o <= line[`FULC_LINE_BRK] ? 1'b0 : tx_line;
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (cyc_i && stb_i && !ack_o) begin
                if (hit_dat) begin
                    dat_o <= {24'h000000, rx_q[7:0]};
                end else if (adr_i == `FULC_IDX_BAUD) begin
                    dat_o <= {16'h0000, baud_divisor};
                end else if (adr_i == `FULC_IDX_IRQ_STAT) begin
                    dat_o <= {27'h0000000, irq_stat};
                end else if (adr_i == `FULC_IDX_IRQ_EN) begin
                    dat_o <= {27'h0000000, irq_en};
                end else if (hit_fif) begin
                    dat_o <= {24'h000000, rx_fill_count,
                              tx_fill_count};
                end else if (adr_i == `FULC_IDX_LINE) begin
                    dat_o <= {24'h000000, line[7:2], head_parity_fault_flag,
                              line[0]};
                end else begin
                    dat_o <= 32'h00000000;
                end
            end
            if (acc && we_i) begin
                if (adr_i == `FULC_IDX_LINE && sel_i[0]) begin
                    line <= dat_i[7:0];
                end else if (adr_i == `FULC_IDX_BAUD) begin
                    if (sel_i[0]) begin
                        baud_divisor[7:0] <= dat_i[7:0];
                    end
                    if (sel_i[1]) begin
                        baud_divisor[15:8] <= dat_i[15:8];
                    end
                end else if (adr_i == `FULC_IDX_IRQ_EN && sel_i[0]) begin
                    irq_en <= dat_i[4:0];
                end else if (hit_fif && sel_i[0]) begin
                    if (dat_i[7:4] != `FULC_RX_THR_CLEAR) begin
                        rx_irq_threshold <= dat_i[7:4];
                    end
                    if (dat_i[3:0] != `FULC_TX_THR_CLEAR) begin
                        tx_irq_threshold <= dat_i[3:0];
                    end
                end
            end
        end
    end
endmodule // fulc_top

// ==== tb/fulc_top_asserts.sv ====
// Bus, reset, break and interrupt checks for the serial controller
`timescale 1ns/100ps
module fulc_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:2] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        rxd_i,
    input wire logic        txd_o,
    input wire logic        irq_o
);
    // ----------
    // Shadow of the bits the checks depend on
    // ----------
    logic       brk;
    logic [4:0] ien;
    wire        wr_hit = ack_o && cyc_i && stb_i && we_i && sel_i[0];
    wire        rd_hit = ack_o && !we_i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            brk <= 1'b0;
            ien <= 5'h00;
        end else if (wr_hit) begin
            if (adr_i == 10'h0c2)
                brk <= dat_i[3];
            if (adr_i == 10'h004)
                ien <= dat_i[4:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without a request");
    a_reset_quiet: assert property ($fell(rst_i) |->
        !ack_o && !irq_o && txd_o && dat_o == 32'h0)
        else $error("outputs not quiet after reset");
    a_unmapped_zero: assert property (rd_hit && !(adr_i inside {10'h000,
        10'h001, 10'h002, 10'h003, 10'h004, 10'h0a5, 10'h0c2}) |->
        dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (rd_hit && adr_i != 10'h001 |->
        dat_o[31:8] == 24'h0)
        else $error("unused read bits not zero");
    a_break_low: assert property (brk [*3] |-> !txd_o)
        else $error("line not low during break");
    a_irq_masked: assert property ((ien == 5'h00) [*3] |-> !irq_o)
        else $error("interrupt with all sources masked");
    c_write: cover property (wr_hit);
    c_read: cover property (rd_hit);
    c_break: cover property (brk && !txd_o);
    c_irq: cover property (irq_o);
endmodule // fulc_top_asserts

bind fulc_top fulc_top_asserts u_fulc_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .irq_o(irq_o));

// ==== tb/fulc_node.sv ====
// Remote serial node: sends frames and samples frames mid-bit
`timescale 1ns/100ps
module fulc_node #(
    parameter int P = 16
) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    // Idle line is high, as a pulled-up serial wire would be
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] d, input int nb, input logic pon,
                        input logic odd, input logic bad, input int ns);
        logic [11:0] f;
        logic        p;
        int          i;
        int          n;
        f = 12'hfff;
        f[0] = 1'b0;
        p = odd;
        for (i = 0; i < nb; i++) begin
            f[1 + i] = d[i];
            p ^= d[i];
        end
        n = 1 + nb;
        if (pon) begin
            f[n] = p ^ bad;
            n++;
        end
        n += ns;
        for (i = 0; i < n; i++)
            repeat (P) @(posedge clk_i) rxd_o <= f[i];
    endtask
    // Bits land in [8:0]; bit 9 stays set while every stop bit was high
    task automatic catch(input int nb, input logic pon, input int ns,
                         output logic [9:0] bits, output int gap);
        int i;
        int n;
        bits = 'x;
        gap = 0;
        n = 0;
        while (txd_i !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (txd_i !== 1'b0)
            return;
        bits = 10'h200;
        repeat (P / 2) @(posedge clk_i);
        for (i = 0; i < nb + pon + ns; i++) begin
            repeat (P) @(posedge clk_i);
            if (i < nb + pon)
                bits[i] = txd_i;
            else if (txd_i !== 1'b1)
                bits[9] = 1'b0;
        end
        gap = P / 2 + (nb + pon + ns) * P;
        n = 0;
        while (txd_i !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            gap++;
            n++;
        end
    endtask
endmodule // fulc_node

// ==== tb/fulc_top_bench.sv ====
// Self-checking bench for the serial controller registers and line
`timescale 1ns/100ps
module fulc_top_bench;
    localparam int DIV = 15;
    localparam int P   = DIV + 1;
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [9:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        rxd_i;
    logic        txd_o;
    logic        irq_o;
    logic [31:0] q;
    int          fail_count;
    int          n_checks;
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    fulc_top u_fulc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .irq_o(irq_o));
    fulc_node #(.P(P)) u_fulc_node (.clk_i(clk_i), .txd_i(txd_o),
        .rxd_o(rxd_i));
    // ----------
    // Reporting and bus access
    // ----------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wb(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask
    function automatic logic [9:0] fexp(logic [7:0] d, int nb, logic [5:0] c);
        logic [9:0] e;
        logic       p;
        e = 10'h200;
        p = c[2];
        for (int i = 0; i < nb; i++) begin
            e[i] = d[i];
            p ^= d[i];
        end
        if (c[0])
            p = 1'b1;
        if (c[1])
            e[nb] = p;
        return e;
    endfunction
    // ----------
    // Scenarios
    // ----------
    task automatic t_idle();
        chk("irq masked", 32'h0, irq_o);
        wb(0, 10'h0c2, 0);
        chk("line reset", 32'h00, q);
        wb(0, 10'h0a5, 0);
        chk("fifo reset", 32'h00, q);
        wb(0, 10'h3ff, 0);
        chk("unmapped", 32'h0, q);
        wb(1, 10'h001, DIV);
        for (int i = 0; i < 16; i++)
            wb(1, 10'h000, i);
        u_fulc_node.send(8'h11, 8, 0, 0, 0, 1);
        wb(1, 10'h0a5, 32'h15);
        wb(0, 10'h0a5, 0);
        chk("fifo full", 32'h0f, q);
        chk("txd idle", 32'h1, txd_o);
        wb(0, 10'h002, 0);
        chk("tx overflow", 32'h10, q & 32'h10);
        wb(1, 10'h001, 0);
        wb(0, 10'h0a5, 0);
        chk("flushed", 32'h00, q);
        wb(0, 10'h002, 0);
        chk("overflow clear", 32'h02, q & 32'h12);
        wb(1, 10'h001, DIV);
    endtask
    // Each entry: two stop, length code, odd, parity on, forced one
    task automatic t_tx();
        logic [5:0] cfg [5] = '{6'h00, 6'h2a, 6'h16, 6'h3b, 6'h1e};
        logic [5:0] c;
        logic [9:0] b0;
        logic [9:0] b1;
        int         gap;
        int         g1;
        int         nb;
        int         f;
        for (int k = 0; k < 5; k++) begin
            c = cfg[k];
            nb = 5 + c[4:3];
            f = 2 + nb + c[1] + c[5];
            wb(1, 10'h0c2, {24'h0, 1'b1, c[5], c[4:3], 1'b0, c[2:0]});
            fork
                begin
                    u_fulc_node.catch(nb, c[1], 1 + c[5], b0, gap);
                    u_fulc_node.catch(nb, c[1], 1 + c[5], b1, g1);
                end
                begin
                    wb(1, 10'h000, 32'ha5);
                    wb(1, 10'h000, 32'h3c);
                end
            join
            chk("frame a", fexp(8'ha5, nb, c), b0);
            chk("frame b", fexp(8'h3c, nb, c), b1);
            chk_rng("frame length", f*P, f*P + 4, gap);
            if (gap == 0)
                final_report();
        end
    endtask
    task automatic t_break();
        int lows;
        wb(1, 10'h0c2, 32'h88);
        repeat (2) @(posedge clk_i);
        lows = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            lows += (txd_o === 1'b0);
        end
        chk("break low", 40, lows);
        wb(1, 10'h0c2, 32'h80);
        repeat (4) @(posedge clk_i);
        chk("break off", 32'h1, txd_o);
    endtask
    task automatic t_rx();
        wb(1, 10'h0c2, 32'hb2);
        wb(1, 10'h0a5, 32'h21);
        wb(1, 10'h004, 32'h01);
        wb(1, 10'h003, 32'h1f);
        u_fulc_node.send(8'h5a, 8, 1, 0, 0, 1);
        repeat (P) @(posedge clk_i);
        chk("irq below", 32'h0, irq_o);
        u_fulc_node.send(8'hc3, 8, 1, 0, 1, 1);
        repeat (P) @(posedge clk_i);
        chk("irq level", 32'h1, irq_o);
        wb(0, 10'h0a5, 0);
        chk("rx count", 32'h20, q);
        wb(0, 10'h0c2, 0);
        chk("good head", 32'hb0, q);
        wb(0, 10'h000, 0);
        chk("rx a", 32'h5a, q);
        repeat (2) @(posedge clk_i);
        wb(0, 10'h0c2, 0);
        chk("bad head", 32'hb2, q);
        wb(0, 10'h000, 0);
        chk("rx b", 32'hc3, q);
        wb(1, 10'h003, 32'h1f);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", 32'h0, irq_o);
        u_fulc_node.send(8'h77, 8, 1, 0, 0, 1);
        repeat (P) @(posedge clk_i);
        wb(1, 10'h0a5, 32'hf1);
        wb(0, 10'h0a5, 0);
        chk("rx cleared", 32'h00, q);
    endtask
    initial begin
        fail_count = 0;
        n_checks = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 10'h000;
        sel_i = 4'h0;
        dat_i = 32'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_idle();
        t_tx();
        t_break();
        t_rx();
        final_report();
    end
endmodule // fulc_top_bench
